// ==== include/rjd_pkg.sv ====
// Purpose: Constants for the refresh scheduler and jitter de-rating logic
// Assumes: 100 MHz controller clock, one refresh scheduler per channel
// Notes: Times are kept in their own unit, cycle counts derived from them
package rjd_pkg;
  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PS = 10000;
  localparam int NUM_CH = 2;
  localparam int NUM_BANKS = 8;
  // ----------------------------------------------------------------
  // Refresh timing, in their printed units
  // ----------------------------------------------------------------
  localparam int REFRESH_WINDOW_MS = 32;
  localparam int REFRESH_WINDOW_HALF_MS = 16;
  localparam int REFRESH_WINDOW_QUARTER_MS = 8;
  localparam int REFRESH_CMDS_PER_WINDOW = 8192;
  localparam int AVG_ALLBANK_REFRESH_INTERVAL_NS = 3904;
  localparam int AVG_PERBANK_REFRESH_INTERVAL_NS = 488;
  localparam int ALLBANK_REFRESH_CYCLE_TIME_NS = 280;
  localparam int PERBANK_REFRESH_CYCLE_TIME_NS = 140;
  localparam int PERBANK_REFRESH_SPACING_NS = 90;
  localparam int SELFREFRESH_ABORT_EXTRA_PS = 17500;
  // ----------------------------------------------------------------
  // Derived cycle counts: intervals round down, minimums round up
  // ----------------------------------------------------------------
  localparam int REFI_AB_CYC = (AVG_ALLBANK_REFRESH_INTERVAL_NS * 1000) / CLK_PS;
  localparam int REFI_PB_CYC = (AVG_PERBANK_REFRESH_INTERVAL_NS * 1000) / CLK_PS;
  localparam int RFC_AB_CYC = (ALLBANK_REFRESH_CYCLE_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int RFC_PB_CYC = (PERBANK_REFRESH_CYCLE_TIME_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PBR_SPACE_CYC = (PERBANK_REFRESH_SPACING_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int XSR_ABORT_CYC =
    (PERBANK_REFRESH_CYCLE_TIME_NS * 1000 + SELFREFRESH_ABORT_EXTRA_PS + CLK_PS - 1) / CLK_PS;
  localparam int WIN_32_CYC = REFRESH_WINDOW_MS * 100000;
  localparam int WIN_16_CYC = REFRESH_WINDOW_HALF_MS * 100000;
  localparam int WIN_8_CYC = REFRESH_WINDOW_QUARTER_MS * 100000;
  localparam int CNT_W = 24;
  // ----------------------------------------------------------------
  // Jitter figures (picoseconds), strobe window in 1/100 clocks
  // ----------------------------------------------------------------
  localparam int PS_W = 20;
  localparam int WSTROBE_MIN_CENTI = 75;
  localparam int WSTROBE_MAX_CENTI = 125;
  localparam int RPRE_MIN_CENTI = 90;
  localparam int NUM_PARAMS = 9;
  // Refresh rate select
  typedef enum logic [1:0] {RJD_RATE_1X, RJD_RATE_2X, RJD_RATE_4X} rjd_rate_t;
endpackage

// ==== logic/rjd_derate.sv ====
// Purpose: Core timing parameter to clock count, with jitter de-rating
// Assumes: Parameter and error values arrive as picoseconds from config logic
// Notes: One registered result per parameter, computed by combinational division in one cycle
`timescale 1ns/10ps
module rjd_derate (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [rjd_pkg::PS_W-1:0] param_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] err_act_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] err_allowed_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] tck_avg_ps_i,
  output logic [15:0] param_clock_count_o,
  output logic [15:0] extra_clocks_o,
  output logic [rjd_pkg::PS_W-1:0] period_derate_ps_o
);
  localparam int PS_W = rjd_pkg::PS_W;
  logic [rjd_pkg::PS_W-1:0] excess;
  logic [rjd_pkg::PS_W-1:0] tck;
  logic [15:0] nom_nxt;
  logic [15:0] der_nxt;
  logic [rjd_pkg::PS_W-1:0] per_nxt;
  // Excess cumulative error; zero when within the allowed figure
  always_comb begin
    tck = (tck_avg_ps_i == '0) ? rjd_pkg::PS_W'(1) : tck_avg_ps_i;
    excess = (err_act_ps_i > err_allowed_ps_i) ? err_act_ps_i - err_allowed_ps_i : '0;
    nom_nxt = 16'((param_ps_i + tck - 1) / tck);
    der_nxt = 16'((param_ps_i + excess + tck - 1) / tck);
    per_nxt = '0;
    if (nom_nxt != 16'h0000) begin
      if ((param_ps_i + excess) / nom_nxt > tck) begin
        per_nxt = PS_W'((param_ps_i + excess) / nom_nxt - tck);
      end
    end
  end
  // Registered results
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      param_clock_count_o <= 16'h0000;
      extra_clocks_o <= 16'h0000;
      period_derate_ps_o <= '0;
    end else begin
      param_clock_count_o <= nom_nxt;
      extra_clocks_o <= (der_nxt > nom_nxt) ? der_nxt - nom_nxt : 16'h0000;
      period_derate_ps_o <= per_nxt;
    end
  end
  // Extra clocks appear only after an error above the allowance
  a_extra_positive: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (extra_clocks_o != 16'h0000) |-> $past(err_act_ps_i > err_allowed_ps_i))
    else $error("extra clocks without excess error");
endmodule

// ==== logic/rjd_refresh_ctrl.sv ====
// Purpose: Per-channel refresh scheduler and timing guard for a two-channel DRAM
// Assumes: Command issue logic asks before refreshing and reports each refresh sent
// Notes: Also derives clock counts and jitter-narrowed strobe windows
//
// What this block does
// - At least 8192 refreshes per 32 ms window
// - Windows shrink to 16 or 8 ms
// - Average interval 3.904 us or 488 ns
// - Wait 280 ns after all-bank refresh
// - Wait 140 ns after per-bank refresh
// - Per-bank refreshes to different banks 90 ns apart
// - Separate refresh bookkeeping for each channel
// - Self refresh abort exit waits extra 17.5 ns
// - Clock count is parameter over period, rounded up
// - Add extra clocks when cumulative error exceeds allowance
// - Period de-rating uses largest positive value
// - Write strobe window narrowed by excess jitter
`timescale 1ns/10ps
module rjd_refresh_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire rjd_pkg::rjd_rate_t rate_i,
  input wire logic perbank_mode_i,
  input wire logic [1:0] ref_ab_sent_i,
  input wire logic [1:0] ref_pb_sent_i,
  input wire logic [2:0] ref_pb_bank_i,
  input wire logic [1:0] sr_abort_i,
  input wire logic [rjd_pkg::PS_W-1:0] tck_avg_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] jit_act_min_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] jit_act_max_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] jit_allow_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] err_act_ps_i,
  input wire logic [rjd_pkg::PS_W-1:0] err_allowed_ps_i,
  input wire logic [3:0] param_sel_i,
  input wire logic [rjd_pkg::PS_W-1:0] param_ps_i,
  output logic [1:0] ref_req_o,
  output logic [1:0] ch_busy_o,
  output logic [15:0] bank_busy_o,
  output logic [1:0] pb_block_o,
  output logic [1:0] window_short_o,
  output logic [15:0] param_clock_count_o,
  output logic [15:0] extra_clocks_o,
  output logic [rjd_pkg::PS_W-1:0] period_derate_max_o,
  output logic [7:0] wstrobe_min_centi_o,
  output logic [7:0] wstrobe_max_centi_o,
  output logic [7:0] read_preamble_len_o
);
  localparam int CW = rjd_pkg::CNT_W;
  // ----------------------------------------------------------------
  // Refresh scheduling, one instance of the logic per channel
  // ----------------------------------------------------------------
  logic [CW-1:0] refi_cyc;
  logic [CW-1:0] win_cyc;
  // Interval follows mode and rate, window follows rate only
  always_comb begin
    refi_cyc = perbank_mode_i ? CW'(rjd_pkg::REFI_PB_CYC) : CW'(rjd_pkg::REFI_AB_CYC);
    case (rate_i)
      rjd_pkg::RJD_RATE_2X: begin
        refi_cyc = refi_cyc >> 1;
        win_cyc = CW'(rjd_pkg::WIN_16_CYC);
      end
      rjd_pkg::RJD_RATE_4X: begin
        refi_cyc = refi_cyc >> 2;
        win_cyc = CW'(rjd_pkg::WIN_8_CYC);
      end
      default: begin
        win_cyc = CW'(rjd_pkg::WIN_32_CYC);
      end
    endcase
  end
  genvar ch;
  generate
    for (ch = 0; ch < rjd_pkg::NUM_CH; ch++) begin : g_ch
      logic [CW-1:0] int_r;
      logic [CW-1:0] win_r;
      logic [13:0] done_r;
      logic req_r;
      logic [CW-1:0] busy_r;
      logic [CW-1:0] space_r;
      logic [7:0] bank_r [8];
      logic short_r;
      logic [2:0] pb_bank_r;
      logic [5:0] ab_quiet_r;
      logic ab_track_r;
      logic sent;
      assign sent = ref_ab_sent_i[ch] | ref_pb_sent_i[ch];
      // Interval counter; a pending request holds until a refresh goes out
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          int_r <= '0;
          req_r <= 1'b0;
        end else begin
          if (int_r >= refi_cyc - 1) begin
            int_r <= '0;
            req_r <= 1'b1;
          end else begin
            int_r <= int_r + CW'(1);
            if (sent) begin
              req_r <= 1'b0;
            end
          end
        end
      end
      // Refresh window count; flags a window that ends short of the minimum
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          win_r <= '0;
          done_r <= '0;
          short_r <= 1'b0;
        end else if (win_r >= win_cyc - 1) begin
          win_r <= '0;
          done_r <= '0;
          short_r <= (done_r < 14'(rjd_pkg::REFRESH_CMDS_PER_WINDOW));
        end else begin
          win_r <= win_r + CW'(1);
          if (sent && done_r != 14'h3FFF) begin
            done_r <= done_r + 14'h0001;
          end
        end
      end
      // Channel-wide busy after all-bank refresh or self refresh abort
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          busy_r <= '0;
        end else if (ref_ab_sent_i[ch]) begin
          busy_r <= CW'(rjd_pkg::RFC_AB_CYC);
        end else if (sr_abort_i[ch]) begin
          busy_r <= CW'(rjd_pkg::XSR_ABORT_CYC);
        end else if (busy_r != '0) begin
          busy_r <= busy_r - CW'(1);
        end
      end
      // Spacing between per-bank refreshes
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          space_r <= '0;
        end else if (ref_pb_sent_i[ch]) begin
          space_r <= CW'(rjd_pkg::PBR_SPACE_CYC);
        end else if (space_r != '0) begin
          space_r <= space_r - CW'(1);
        end
      end
      // Per-bank busy timers
      for (genvar b = 0; b < rjd_pkg::NUM_BANKS; b++) begin : g_bank
        always_ff @(posedge clk_i or negedge resetn_i) begin
          if (!resetn_i) begin
            bank_r[b] <= 8'h00;
          end else if (ref_pb_sent_i[ch] && ref_pb_bank_i == 3'(b)) begin
            bank_r[b] <= 8'(rjd_pkg::RFC_PB_CYC);
          end else if (bank_r[b] != 8'h00) begin
            bank_r[b] <= bank_r[b] - 8'h01;
          end
        end
        assign bank_busy_o[ch*8+b] = (bank_r[b] != 8'h00) || (busy_r != '0);
      end
      assign ref_req_o[ch] = req_r;
      assign ch_busy_o[ch] = (busy_r != '0);
      assign pb_block_o[ch] = (space_r != '0) || (busy_r != '0);
      assign window_short_o[ch] = short_r;
      // Last bank refreshed on this channel; the shared bank pins may move on
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pb_bank_r <= 3'h0;
        end else if (ref_pb_sent_i[ch]) begin
          pb_bank_r <= ref_pb_bank_i;
        end
      end
      // Quiet cycles since an all-bank refresh, for the release check
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ab_quiet_r <= 6'h00;
          ab_track_r <= 1'b0;
        end else if (ref_ab_sent_i[ch] && !sr_abort_i[ch]) begin
          ab_quiet_r <= 6'h00;
          ab_track_r <= 1'b1;
        end else if (ref_ab_sent_i[ch] || sr_abort_i[ch]) begin
          ab_track_r <= 1'b0;
        end else if (ab_quiet_r != 6'h3F) begin
          ab_quiet_r <= ab_quiet_r + 6'h01;
        end
      end
      a_abort_exit_hold: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (sr_abort_i[ch] && !ref_ab_sent_i[ch]) |=> ch_busy_o[ch] [*8])
        else $error("abort exit released early");
      a_allbank_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ref_ab_sent_i[ch] |=> ch_busy_o[ch] [*8])
        else $error("all-bank refresh busy too short");
      a_allbank_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ab_track_r && ab_quiet_r == 6'(rjd_pkg::RFC_AB_CYC)) |-> !ch_busy_o[ch])
        else $error("all-bank refresh busy too long");
      a_pb_spacing: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ref_pb_sent_i[ch] |=> pb_block_o[ch] [*8])
        else $error("per-bank spacing too short");
      a_pb_bank_busy: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ref_pb_sent_i[ch] |=> bank_busy_o[ch*8+pb_bank_r] [*8])
        else $error("per-bank busy too short");
      a_req_on_expiry: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (int_r >= refi_cyc - 1) |=> ref_req_o[ch])
        else $error("refresh request missing on expiry");
      a_req_held: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (ref_req_o[ch] && !sent) |=> ref_req_o[ch])
        else $error("refresh request dropped without refresh");
    end
  endgenerate
  // Bookkeeping stays per channel: with equal rate, counters run alike
  a_ch_independent: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (ref_ab_sent_i[0] && !ref_ab_sent_i[1] && !sr_abort_i[1] && !ch_busy_o[1])
    |=> !ch_busy_o[1])
    else $error("refresh leaked into other channel");
  // ----------------------------------------------------------------
  // Core parameter clock counts and de-rating
  // ----------------------------------------------------------------
  logic [15:0] nom_cnt;
  logic [15:0] extra_cnt;
  logic [rjd_pkg::PS_W-1:0] per_derate;
  logic [3:0] sel_r;
  rjd_derate u_derate (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .param_ps_i(param_ps_i),
    .err_act_ps_i(err_act_ps_i),
    .err_allowed_ps_i(err_allowed_ps_i),
    .tck_avg_ps_i(tck_avg_ps_i),
    .param_clock_count_o(nom_cnt),
    .extra_clocks_o(extra_cnt),
    .period_derate_ps_o(per_derate)
  );
  // Parameter select follows the derate latency of one cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_r <= 4'h0;
    end else begin
      sel_r <= param_sel_i;
    end
  end
  // Outputs per parameter; period derate is the largest seen since reset for selects below NUM_PARAMS
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      param_clock_count_o <= 16'h0000;
      extra_clocks_o <= 16'h0000;
      period_derate_max_o <= '0;
    end else begin
      param_clock_count_o <= nom_cnt;
      extra_clocks_o <= extra_cnt;
      if (sel_r < 4'(rjd_pkg::NUM_PARAMS) && per_derate > period_derate_max_o) begin
        period_derate_max_o <= per_derate;
      end
    end
  end
  a_derate_max: assert property (@(posedge clk_i) disable iff (!resetn_i)
    period_derate_max_o >= $past(period_derate_max_o))
    else $error("period derate decreased");
  // ----------------------------------------------------------------
  // Jitter-narrowed strobe window and read preamble, in 1/100 clock
  // ----------------------------------------------------------------
  logic [rjd_pkg::PS_W-1:0] tck_nz;
  logic [rjd_pkg::PS_W-1:0] ex_max;
  logic [rjd_pkg::PS_W-1:0] ex_min;
  logic [rjd_pkg::PS_W+6:0] ex_max_c;
  logic [rjd_pkg::PS_W+6:0] ex_min_c;
  // Excess jitter converted to hundredths of a clock, rounded up
  always_comb begin
    tck_nz = (tck_avg_ps_i == '0) ? rjd_pkg::PS_W'(1) : tck_avg_ps_i;
    ex_max = (jit_act_max_ps_i > jit_allow_ps_i) ? jit_act_max_ps_i - jit_allow_ps_i : '0;
    ex_min = (jit_act_min_ps_i > jit_allow_ps_i) ? jit_act_min_ps_i - jit_allow_ps_i : '0;
    ex_max_c = ((27'(ex_max) * 27'h64) + 27'(tck_nz) - 27'h1) / 27'(tck_nz);
    ex_min_c = ((27'(ex_min) * 27'h64) + 27'(tck_nz) - 27'h1) / 27'(tck_nz);
  end
  // Min edge moves later and max edge earlier: the window only narrows
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wstrobe_min_centi_o <= 8'(rjd_pkg::WSTROBE_MIN_CENTI);
      wstrobe_max_centi_o <= 8'(rjd_pkg::WSTROBE_MAX_CENTI);
      read_preamble_len_o <= 8'(rjd_pkg::RPRE_MIN_CENTI);
    end else begin
      wstrobe_min_centi_o <= (ex_min_c > 27'h32) ? 8'h7D :
        8'(27'(rjd_pkg::WSTROBE_MIN_CENTI) + ex_min_c);
      wstrobe_max_centi_o <= (ex_max_c > 27'h32) ? 8'h4B :
        8'(27'(rjd_pkg::WSTROBE_MAX_CENTI) - ex_max_c);
      read_preamble_len_o <= (ex_max_c > 27'h5A) ? 8'h00 :
        8'(27'(rjd_pkg::RPRE_MIN_CENTI) - ex_max_c);
    end
  end
  a_wstrobe_narrow: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wstrobe_min_centi_o >= 8'h4B && wstrobe_max_centi_o <= 8'h7D)
    else $error("strobe window widened");
  a_preamble_cut: assert property (@(posedge clk_i) disable iff (!resetn_i)
    read_preamble_len_o <= 8'h5A)
    else $error("read preamble above nominal");
endmodule

// ==== tb/rjd_dram_model.sv ====
// Purpose: Device-side model that takes refresh traffic and checks its spacing
// Assumes: Refresh and abort pulses are one clock wide, per channel
// Notes: Each failed check adds one to viol_o (channel and spacing waits share one check); all-bank and abort commands check only the channel wait
`timescale 1ns/10ps
module rjd_dram_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [1:0] ref_ab_sent_i,
  input wire logic [1:0] ref_pb_sent_i,
  input wire logic [2:0] ref_pb_bank_i,
  input wire logic [1:0] sr_abort_i,
  output int viol_o,
  output int refs_o
);
  // ----------------------------------------------------------------
  // Per-channel wait counters
  // ----------------------------------------------------------------
  int busy_ch [2];
  int space [2];
  int busy_bk [16];

  // Each channel keeps its own waits; violation and refresh counts are shared
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      viol_o = 0;
      refs_o = 0;
      foreach (busy_ch[c]) begin
        busy_ch[c] = 0;
        space[c] = 0;
      end
      foreach (busy_bk[b]) busy_bk[b] = 0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (busy_ch[c] > 0) busy_ch[c]--;
        if (space[c] > 0) space[c]--;
        for (int b = 0; b < 8; b++) if (busy_bk[c*8+b] > 0) busy_bk[c*8+b]--;
        // Commands inside a wait are early
        if ((ref_ab_sent_i[c] || sr_abort_i[c]) && busy_ch[c] > 0) viol_o++;
        if (ref_pb_sent_i[c] && (busy_ch[c] > 0 || space[c] > 0)) viol_o++;
        if (ref_pb_sent_i[c] && busy_bk[c*8+ref_pb_bank_i] > 0) viol_o++;
        if (ref_ab_sent_i[c]) busy_ch[c] = rjd_pkg::RFC_AB_CYC;
        else if (sr_abort_i[c]) busy_ch[c] = rjd_pkg::XSR_ABORT_CYC;
        if (ref_pb_sent_i[c]) begin
          busy_bk[c*8+ref_pb_bank_i] = rjd_pkg::RFC_PB_CYC;
          space[c] = rjd_pkg::PBR_SPACE_CYC;
        end
        if (ref_ab_sent_i[c] || ref_pb_sent_i[c]) refs_o++;
      end
    end
  end
endmodule

// ==== tb/rjd_refresh_and_jitter_derating_bench.sv ====
// Purpose: Self-checking bench for the refresh scheduler and de-rating logic
// Assumes: Inputs change on the falling clock edge, outputs sampled there too
// Notes: Random traffic from a fixed seed, with hand-picked corner cases
`timescale 1ns/10ps
module rjd_refresh_and_jitter_derating_bench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rjd_pkg::rjd_rate_t rate;
  logic perbank_mode;
  logic [1:0] ref_ab_sent, ref_pb_sent, sr_abort, ref_req, ch_busy, pb_block, window_short;
  logic [2:0] ref_pb_bank;
  logic [3:0] param_sel;
  logic [19:0] tck_ps, jmin_ps, jmax_ps, jallow_ps, err_act_ps, err_allow_ps, param_ps, derate;
  logic [15:0] bank_busy, count, extra;
  logic [7:0] ws_min, ws_max, preamble;
  int errors = 0, comparisons = 0, seed = 84149, viol, refs, n, m, e, ch, bk;

  rjd_refresh_ctrl rjd_refresh_ctrl_i (.clk_i(clk_i), .resetn_i(resetn_i), .rate_i(rate),
    .perbank_mode_i(perbank_mode), .ref_ab_sent_i(ref_ab_sent), .ref_pb_sent_i(ref_pb_sent),
    .ref_pb_bank_i(ref_pb_bank), .sr_abort_i(sr_abort), .tck_avg_ps_i(tck_ps),
    .jit_act_min_ps_i(jmin_ps), .jit_act_max_ps_i(jmax_ps), .jit_allow_ps_i(jallow_ps),
    .err_act_ps_i(err_act_ps), .err_allowed_ps_i(err_allow_ps), .param_sel_i(param_sel),
    .param_ps_i(param_ps), .ref_req_o(ref_req), .ch_busy_o(ch_busy), .bank_busy_o(bank_busy),
    .pb_block_o(pb_block), .window_short_o(window_short), .param_clock_count_o(count),
    .extra_clocks_o(extra), .period_derate_max_o(derate), .wstrobe_min_centi_o(ws_min),
    .wstrobe_max_centi_o(ws_max), .read_preamble_len_o(preamble));
  rjd_dram_model rjd_dram_model_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .ref_ab_sent_i(ref_ab_sent), .ref_pb_sent_i(ref_pb_sent), .ref_pb_bank_i(ref_pb_bank),
    .sr_abort_i(sr_abort), .viol_o(viol), .refs_o(refs));

  // Clock at 100 MHz
  always #5 clk_i = ~clk_i;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic int ceil_div(input int a, input int b);
    return (a + b - 1) / b;
  endfunction
  function automatic int centi(input int base, input int excess, input int tck);
    return base - (excess * 100) / tck;
  endfunction
  function automatic int interval(input int r, input int pb);
    return (pb != 0 ? rjd_pkg::REFI_PB_CYC : rjd_pkg::REFI_AB_CYC) >> r;
  endfunction
  function automatic logic sig(input int which, input int idx);
    case (which)
      0: return ch_busy[idx];
      1: return bank_busy[idx];
      default: return pb_block[idx];
    endcase
  endfunction
  task automatic give_verdict;
    $display("Counts: comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp_flag(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t flag %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t value %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask
  task automatic do_reset;
    resetn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
  endtask
  // Kind 0 all-bank, 1 per-bank, 2 self refresh abort
  task automatic send(input int kind, input int c, input int b);
    @(negedge clk_i);
    if (kind == 0) ref_ab_sent[c] = 1'b1;
    else if (kind == 1) ref_pb_sent[c] = 1'b1;
    else sr_abort[c] = 1'b1;
    ref_pb_bank = 3'(b);
    @(negedge clk_i);
    ref_ab_sent = 2'h0;
    ref_pb_sent = 2'h0;
    sr_abort = 2'h0;
  endtask
  task automatic span(input int which, input int idx, output int len);
    int w;
    len = 0;
    w = 0;
    while (sig(which, idx) !== 1'b1 && w < 3) begin
      @(negedge clk_i);
      w++;
    end
    while (sig(which, idx) === 1'b1 && len < 60) begin
      @(negedge clk_i);
      len++;
    end
  endtask
  task automatic set_param(input int sel, input int p, input int act, input int allow);
    param_sel = 4'(sel);
    param_ps = 20'(p);
    err_act_ps = 20'(act);
    err_allow_ps = 20'(allow);
    repeat (3) @(negedge clk_i);
  endtask

  // Watchdog sized well past the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    errors++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rate = rjd_pkg::RJD_RATE_1X;
    perbank_mode = 1'b0;
    {ref_ab_sent, ref_pb_sent, sr_abort, ref_pb_bank, param_sel} = '0;
    {jmin_ps, jmax_ps, jallow_ps, err_act_ps, err_allow_ps, param_ps} = '0;
    tck_ps = 20'h02710;
    do_reset();
    @(negedge clk_i);
    cmp_val({12'h000, ws_min}, 20'(rjd_pkg::WSTROBE_MIN_CENTI), "reset min");
    cmp_val({12'h000, ws_max}, 20'(rjd_pkg::WSTROBE_MAX_CENTI), "reset max");
    cmp_val({12'h000, preamble}, 20'(rjd_pkg::RPRE_MIN_CENTI), "reset pre");
    cmp_val({14'h0000, ref_req, ch_busy, window_short}, 20'h00000, "reset flags");
    // Wait lengths after each command kind
    send(0, 0, 0);
    cmp_flag(ch_busy[1], 1'b0, "other channel");
    span(0, 0, n);
    cmp_val(20'(n), 20'(rjd_pkg::RFC_AB_CYC), "all-bank wait");
    send(2, 1, 0);
    span(0, 1, n);
    cmp_val(20'(n), 20'(rjd_pkg::XSR_ABORT_CYC), "abort wait");
    send(1, 0, 3);
    cmp_flag(bank_busy[5] | bank_busy[11], 1'b0, "other banks");
    span(2, 0, n);
    cmp_val(20'(n), 20'(rjd_pkg::PBR_SPACE_CYC), "spacing");
    span(1, 3, m);
    cmp_val(20'(n + m), 20'(rjd_pkg::RFC_PB_CYC), "bank wait");
    send(0, 0, 0);
    cmp_flag(bank_busy[7] & pb_block[0], 1'b1, "all-bank blocks banks");
    span(0, 0, n);
    // Random per-bank traffic that obeys the reported waits
    for (int i = 0; i < 12; i++) begin
      ch = $unsigned($random(seed)) % 2;
      bk = $unsigned($random(seed)) % 8;
      e = 0;
      while ((pb_block[ch] | bank_busy[ch*8+bk]) !== 1'b0 && e < 40) begin
        @(negedge clk_i);
        e++;
      end
      send(1, ch, bk);
    end
    repeat (20) @(negedge clk_i);
    cmp_val(20'(viol), 20'h00000, "device timing");
    cmp_val(20'(refs), 20'h0000F, "refresh count");
    // Clock counts, extra clocks and the sticky period de-rating
    set_param(0, 18000, 5000, 1000);
    cmp_val({4'h0, count}, 20'h00002, "count");
    cmp_val({4'h0, extra}, 20'h00001, "extra");
    cmp_val(derate, 20'h003E8, "derate");
    set_param(1, 30000, 700, 700);
    cmp_val({4'h0, count}, 20'h00003, "exact count");
    cmp_val(derate, 20'h003E8, "derate kept");
    set_param(2, 40000, 9000, 1000);
    cmp_val(derate, 20'h007D0, "derate max");
    set_param(9, 40000, 30000, 1000);
    cmp_val(derate, 20'h007D0, "derate other select");
    // Jitter-narrowed strobe window and preamble
    jmin_ps = 20'h00BB8;
    jmax_ps = 20'h009C4;
    jallow_ps = 20'h007D0;
    repeat (3) @(negedge clk_i);
    e = centi(rjd_pkg::WSTROBE_MIN_CENTI, 2000 - 3000, 10000);
    cmp_val({12'h000, ws_min}, 20'(e), "strobe min");
    e = centi(rjd_pkg::WSTROBE_MAX_CENTI, 2500 - 2000, 10000);
    cmp_val({12'h000, ws_max}, 20'(e), "strobe max");
    e = centi(rjd_pkg::RPRE_MIN_CENTI, 2500 - 2000, 10000);
    cmp_val({12'h000, preamble}, 20'(e), "preamble");
    for (int i = 0; i < 16; i++) begin
      tck_ps = 20'(1000 + $unsigned($random(seed)) % 9000);
      n = 5000 + $unsigned($random(seed)) % 60000;
      m = $unsigned($random(seed)) % 500;
      e = m + $unsigned($random(seed)) % 2000;
      set_param(i % 9, n, e, m);
      cmp_val({4'h0, count}, 20'(ceil_div(n, tck_ps)), "rnd count");
      e = ceil_div(n + e - m, tck_ps) - ceil_div(n, tck_ps);
      cmp_val({4'h0, extra}, 20'(e), "rnd extra");
    end
    // Refresh interval for every rate and mode, channels apart
    for (int r = 0; r < 3; r++) begin
      for (int pb = 0; pb < 2; pb++) begin
        rate = rjd_pkg::rjd_rate_t'(r);
        perbank_mode = 1'(pb);
        do_reset();
        n = 0;
        while (ref_req[0] !== 1'b1 && n < 500) begin
          @(negedge clk_i);
          n++;
        end
        e = interval(r, pb);
        cmp_flag(n >= e - 2 && n <= e + 2, 1'b1, "interval");
        cmp_flag(ref_req[1], 1'b1, "channel 1 due");
        send(pb, 0, 0);
        cmp_flag(ref_req[0], 1'b0, "request cleared");
        cmp_flag(ref_req[1], 1'b1, "request held");
      end
    end
    give_verdict();
  end
endmodule
